// ===== design/ems_pkg.sv
// Notes on behaviour
// - control bit 0: shared pin is memory output enable, active low.
// - control bit 1: shared pin flags access pending while bus is given away.
// - active-low write strobe controls writes into external memory.
// - address strobe low only while a valid address is driven.
// - read: data strobe tells memory it may now drive the data bus.
// - write: data strobe low only while write data is valid on the bus.
// - cycle initiate pulses low at the start of every transaction.
// - direction output high for read, low for write.
// - transaction completes only after ready input is sampled low.
// - bus request low: address, data and control outputs released.
// - grant acknowledge low only after all lines are released; code keeps byte selects and the pending-mode shared pin driven.
// - four active-low byte selects, one per byte lane 0 to 3.
package ems_pkg;
	typedef enum logic [2:0] {
		EMS_IDLE,
		EMS_ADDR,
		EMS_DATA,
		EMS_FLOAT,
		EMS_GRANT
	} ems_phase_type;

	localparam logic EMS_PIN_IDLE = 1'h1;
	localparam logic EMS_PIN_ACT  = 1'h0;
	localparam logic EMS_OE_OFF   = 1'h0;
	localparam logic EMS_OE_ON    = 1'h1;
	localparam logic EMS_RW_READ  = 1'h1;
	localparam logic EMS_RW_WRITE = 1'h0;
	localparam logic EMS_MODE_OE  = 1'h0;
	localparam int   EMS_LANES    = 4;
	localparam int   EMS_DATA_W   = 32;
	localparam int   EMS_ADDR_W   = 24;

	function automatic logic ems_owns_bus(input ems_phase_type ph);
		return !(ph == EMS_FLOAT || ph == EMS_GRANT);
	endfunction : ems_owns_bus

	function automatic logic ems_in_xfer(input ems_phase_type ph);
		return ph == EMS_ADDR || ph == EMS_DATA;
	endfunction : ems_in_xfer
endpackage : ems_pkg

// ===== design/ems_strobe_gen.sv
`timescale 1ns/1ns
module ems_strobe_gen
	import ems_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire logic          arst_n,
	input  wire ems_phase_type phase_d,
	input  wire logic          write_d,
	input  wire logic          pending_d,
	input  wire logic          oe_pin_mode,
	output logic               cycle_initiate_n,
	output logic               addr_strobe_n,
	output logic               data_strobe_n,
	output logic               mem_write_strobe_n,
	output logic               read_not_write,
	output logic               ctrl_oe,
	output logic               mem_oe_pend_n,
	output logic               mem_oe_pend_oe,
	output logic               bus_grant_ack_n
);
	typedef struct packed {
		logic cyc;
		logic as;
		logic ds;
		logic mw;
		logic rw;
		logic coe;
		logic pin;
		logic pin_oe;
		logic ack;
	} ems_strobe_type;

	ems_strobe_type q;
	ems_strobe_type d;
	logic           mem_output_enable_n;
	logic           ext_access_pending_n;

	always_comb begin
		mem_output_enable_n  = !(phase_d == EMS_DATA && !write_d);
		ext_access_pending_n = !pending_d;
		d     = q;
		d.cyc = !(phase_d == EMS_ADDR);
		d.as  = !ems_in_xfer(phase_d);
		d.ds  = !(phase_d == EMS_DATA);
		d.mw  = !(phase_d == EMS_DATA && write_d);
		if (ems_in_xfer(phase_d)) begin
			d.rw = write_d ? EMS_RW_WRITE : EMS_RW_READ;
		end
		d.coe = ems_owns_bus(phase_d) ? EMS_OE_ON : EMS_OE_OFF;
		d.ack = (phase_d == EMS_GRANT) ? EMS_PIN_ACT : EMS_PIN_IDLE;
		// pending flag must drive even while the bus is given away
		if (oe_pin_mode == EMS_MODE_OE) begin
			d.pin    = mem_output_enable_n;
			d.pin_oe = d.coe;
		end else begin
			d.pin    = ext_access_pending_n;
			d.pin_oe = EMS_OE_ON;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{EMS_PIN_IDLE, EMS_PIN_IDLE, EMS_PIN_IDLE, EMS_PIN_IDLE,
				EMS_RW_READ, EMS_OE_ON, EMS_PIN_IDLE, EMS_OE_ON,
				EMS_PIN_IDLE};
		end else begin
			q <= d;
		end
	end

	assign cycle_initiate_n   = q.cyc;
	assign addr_strobe_n      = q.as;
	assign data_strobe_n      = q.ds;
	assign mem_write_strobe_n = q.mw;
	assign read_not_write     = q.rw;
	assign ctrl_oe            = q.coe;
	assign mem_oe_pend_n      = q.pin;
	assign mem_oe_pend_oe     = q.pin_oe;
	assign bus_grant_ack_n    = q.ack;
endmodule : ems_strobe_gen

// ===== design/ems_data_path.sv
`timescale 1ns/1ns
module ems_data_path
	import ems_pkg::*;
#(
	parameter int ADDR_W = EMS_ADDR_W,
	parameter int DATA_W = EMS_DATA_W
) (
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire ems_phase_type       phase_d,
	input  wire logic                write_d,
	input  wire logic                load,
	input  wire logic                capture,
	input  wire logic [ADDR_W-1:0]   req_addr,
	input  wire logic [DATA_W-1:0]   req_wdata,
	input  wire logic [DATA_W/8-1:0] req_byte_en,
	input  wire logic [DATA_W-1:0]   mem_data_in,
	output logic [ADDR_W-1:0]        mem_addr,
	output logic                     mem_addr_oe,
	output logic [DATA_W-1:0]        mem_data_out,
	output logic                     mem_data_oe,
	output logic [DATA_W/8-1:0]      byte_select_n,
	output logic [DATA_W-1:0]        rsp_rdata
);
	typedef struct packed {
		logic [ADDR_W-1:0]   addr;
		logic                aoe;
		logic [DATA_W-1:0]   wdata;
		logic                doe;
		logic [DATA_W/8-1:0] bsel_n;
		logic [DATA_W-1:0]   rdata;
	} ems_path_type;

	ems_path_type q;
	ems_path_type d;

	always_comb begin
		d     = q;
		d.aoe = ems_owns_bus(phase_d) ? EMS_OE_ON : EMS_OE_OFF;
		d.doe = (write_d && ems_in_xfer(phase_d)) ? EMS_OE_ON
			: EMS_OE_OFF;
		if (load) begin
			d.addr   = req_addr;
			d.wdata  = req_wdata;
			d.bsel_n = ~req_byte_en;
		end else if (!ems_in_xfer(phase_d)) begin
			d.bsel_n = '1;
		end
		if (capture) begin
			d.rdata = mem_data_in;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{'0, EMS_OE_ON, '0, EMS_OE_OFF, '1, '0};
		end else begin
			q <= d;
		end
	end

	assign mem_addr      = q.addr;
	assign mem_addr_oe   = q.aoe;
	assign mem_data_out  = q.wdata;
	assign mem_data_oe   = q.doe;
	assign byte_select_n = q.bsel_n;
	assign rsp_rdata     = q.rdata;
endmodule : ems_data_path

// ===== design/ems_bus_interface.sv
`timescale 1ns/1ns
module ems_bus_interface
	import ems_pkg::*;
#(
	parameter int ADDR_W = EMS_ADDR_W,
	parameter int DATA_W = EMS_DATA_W
) (
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire logic                req_valid,
	output logic                     req_ready,
	input  wire logic                req_write,
	input  wire logic [ADDR_W-1:0]   req_addr,
	input  wire logic [DATA_W-1:0]   req_wdata,
	input  wire logic [DATA_W/8-1:0] req_byte_en,
	output logic                     rsp_valid,
	output logic [DATA_W-1:0]        rsp_rdata,
	input  wire logic                oe_pin_mode,
	output logic [ADDR_W-1:0]        mem_addr,
	output logic                     mem_addr_oe,
	output logic [DATA_W-1:0]        mem_data_out,
	output logic                     mem_data_oe,
	input  wire logic [DATA_W-1:0]   mem_data_in,
	output logic [DATA_W/8-1:0]      byte_select_n,
	output logic                     cycle_initiate_n,
	output logic                     addr_strobe_n,
	output logic                     data_strobe_n,
	output logic                     mem_write_strobe_n,
	output logic                     read_not_write,
	output logic                     ctrl_oe,
	output logic                     mem_oe_pend_n,
	output logic                     mem_oe_pend_oe,
	input  wire logic                sync_ready_n,
	input  wire logic                bus_request_n,
	output logic                     bus_grant_ack_n
);
	typedef struct packed {
		ems_phase_type phase;
		logic          write;
		logic          ready;
		logic          rsp;
	} ems_ctrl_type;

	ems_ctrl_type q;
	ems_ctrl_type d;
	logic         take;
	logic         done;
	logic         pending;

	always_comb begin
		take    = req_valid && q.ready;
		done    = (q.phase == EMS_DATA) && !sync_ready_n;
		pending = 1'b0;
		d       = q;
		d.rsp   = done;
		case (q.phase)
			EMS_IDLE: begin
				// a request taken in the same cycle as a bus request wins
				if (take) begin
					d.phase = EMS_ADDR;
					d.write = req_write;
				end else if (!bus_request_n) begin
					d.phase = EMS_FLOAT;
				end
			end
			EMS_ADDR: begin
				d.phase = EMS_DATA;
			end
			EMS_DATA: begin
				// stays here with all pins frozen until ready is seen
				if (done) begin
					d.phase = EMS_IDLE;
				end
			end
			EMS_FLOAT: begin
				// outputs are already off; grant goes out one cycle later
				if (bus_request_n) begin
					d.phase = EMS_IDLE;
				end else begin
					d.phase = EMS_GRANT;
				end
			end
			EMS_GRANT: begin
				// memory belongs to the other master until its request drops
				if (bus_request_n) begin
					d.phase = EMS_IDLE;
				end
			end
			default: begin
				d.phase = EMS_IDLE;
			end
		endcase
		if (!ems_owns_bus(d.phase)) begin
			pending = req_valid;
		end
		d.ready = (d.phase == EMS_IDLE);
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{EMS_IDLE, 1'h0, 1'h0, 1'h0};
		end else begin
			q <= d;
		end
	end

	assign req_ready = q.ready;
	assign rsp_valid = q.rsp;

	ems_strobe_gen u_strobe (
		.sys_clk            (sys_clk),
		.arst_n             (arst_n),
		.phase_d            (d.phase),
		.write_d            (d.write),
		.pending_d          (pending),
		.oe_pin_mode        (oe_pin_mode),
		.cycle_initiate_n   (cycle_initiate_n),
		.addr_strobe_n      (addr_strobe_n),
		.data_strobe_n      (data_strobe_n),
		.mem_write_strobe_n (mem_write_strobe_n),
		.read_not_write     (read_not_write),
		.ctrl_oe            (ctrl_oe),
		.mem_oe_pend_n      (mem_oe_pend_n),
		.mem_oe_pend_oe     (mem_oe_pend_oe),
		.bus_grant_ack_n    (bus_grant_ack_n)
	);

	ems_data_path #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W)
	) u_path (
		.sys_clk       (sys_clk),
		.arst_n        (arst_n),
		.phase_d       (d.phase),
		.write_d       (d.write),
		.load          (take),
		.capture       (done && !q.write),
		.req_addr      (req_addr),
		.req_wdata     (req_wdata),
		.req_byte_en   (req_byte_en),
		.mem_data_in   (mem_data_in),
		.mem_addr      (mem_addr),
		.mem_addr_oe   (mem_addr_oe),
		.mem_data_out  (mem_data_out),
		.mem_data_oe   (mem_data_oe),
		.byte_select_n (byte_select_n),
		.rsp_rdata     (rsp_rdata)
	);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	chk_shared_oe_mode: assert property (
		$past(oe_pin_mode) == EMS_MODE_OE && !data_strobe_n
			&& read_not_write |-> !mem_oe_pend_n && mem_oe_pend_oe)
		else $error("output enable not low during read data phase");

	chk_pending_flag: assert property (
		$past(oe_pin_mode && req_valid) && !ctrl_oe
			|-> !mem_oe_pend_n && mem_oe_pend_oe)
		else $error("access pending flag missing while bus released");

	chk_write_strobe_dir: assert property (
		!mem_write_strobe_n |-> !read_not_write && !data_strobe_n)
		else $error("write strobe outside a write data phase");

	chk_addr_strobe_valid: assert property (
		!addr_strobe_n |-> mem_addr_oe && ctrl_oe && $stable(mem_addr)
			|| $fell(addr_strobe_n))
		else $error("address strobe without a stable driven address");

	chk_ds_after_cycle: assert property (
		$fell(data_strobe_n) |-> $past(!cycle_initiate_n)
			&& !addr_strobe_n)
		else $error("data strobe not preceded by cycle initiate");

	chk_write_data_valid: assert property (
		!data_strobe_n && !read_not_write |-> mem_data_oe)
		else $error("write data not driven under data strobe");

	chk_cycle_one_pulse: assert property (
		$fell(cycle_initiate_n) |-> !addr_strobe_n
			##1 cycle_initiate_n && !data_strobe_n)
		else $error("cycle initiate not a single-cycle start pulse");

	chk_rw_direction: assert property (
		$fell(cycle_initiate_n) |-> read_not_write
			== (q.write ? EMS_RW_WRITE : EMS_RW_READ))
		else $error("direction output does not match transaction");

	chk_ready_completes: assert property (
		rsp_valid |-> $past(!sync_ready_n) && $past(!data_strobe_n)
			##1 data_strobe_n)
		else $error("transaction ended without ready sampled");

	chk_float_on_req: assert property (
		q.phase == EMS_IDLE && !take && !bus_request_n
			|=> !ctrl_oe && !mem_addr_oe && !mem_data_oe)
		else $error("outputs not released on bus request");

	chk_ack_after_release: assert property (
		$fell(bus_grant_ack_n) |-> $past(!ctrl_oe && !mem_addr_oe
			&& !mem_data_oe, 1))
		else $error("grant given before lines were released");

	chk_wait_hold: assert property (
		!data_strobe_n && $past(!data_strobe_n) |-> $past(sync_ready_n)
			&& $stable(mem_addr) && $stable(read_not_write)
			&& !addr_strobe_n)
		else $error("pins moved during a wait cycle");

	chk_finish_first: assert property (
		$fell(ctrl_oe) |-> $past(data_strobe_n) && $past(addr_strobe_n))
		else $error("bus released in mid transaction");

	chk_resume_bus: assert property (
		!bus_grant_ack_n && bus_request_n |=> bus_grant_ack_n && ctrl_oe
			&& mem_addr_oe)
		else $error("bus not resumed after request withdrawn");

	// released pins float, so these only check what the flops hold
	chk_ack_lines_off: assert property (
		!bus_grant_ack_n |-> !ctrl_oe && !mem_addr_oe && !mem_data_oe)
		else $error("lines driven while grant is given");

	chk_bsel_idle: assert property (
		addr_strobe_n |-> byte_select_n == '1)
		else $error("byte selects active outside a transfer");

	chk_bsel_stable: assert property (
		!addr_strobe_n && $past(!addr_strobe_n) |-> $stable(byte_select_n))
		else $error("byte selects moved inside a transfer");

	chk_ready_waits: assert property (
		!data_strobe_n && sync_ready_n |=> !data_strobe_n)
		else $error("data phase ended without ready");

	chk_ready_ends: assert property (
		!data_strobe_n && !sync_ready_n |=> data_strobe_n && rsp_valid)
		else $error("ready seen but transaction not completed");

	chk_rsp_one_cycle: assert property (
		rsp_valid |=> !rsp_valid)
		else $error("completion pulse longer than one cycle");

	chk_pend_mode_drive: assert property (
		$past(oe_pin_mode) |-> mem_oe_pend_oe)
		else $error("pending flag pin not driven in pending mode");

	chk_pend_owned_high: assert property (
		$past(oe_pin_mode) && ctrl_oe |-> mem_oe_pend_n)
		else $error("pending flag low while bus is owned");

	chk_pend_tracks: assert property (
		$past(oe_pin_mode) && !ctrl_oe
			|-> mem_oe_pend_n == !$past(req_valid))
		else $error("pending flag does not follow the waiting access");

	chk_oe_pin_idle: assert property (
		!$past(oe_pin_mode) && data_strobe_n |-> mem_oe_pend_n)
		else $error("output enable low outside a data phase");

	chk_wstb_reads: assert property (
		read_not_write |-> mem_write_strobe_n)
		else $error("write strobe low during a read");

	chk_dir_held: assert property (
		addr_strobe_n |-> $stable(read_not_write))
		else $error("direction changed outside a transfer");

	chk_cyc_on_take: assert property (
		!cycle_initiate_n |-> $past(req_valid && req_ready))
		else $error("cycle initiate without an accepted request");

	chk_no_start_granted: assert property (
		!bus_grant_ack_n |-> cycle_initiate_n && addr_strobe_n
			&& data_strobe_n)
		else $error("transfer running while bus is given away");

	cov_back_to_back: cover property (
		rsp_valid ##1 !cycle_initiate_n);
	cov_read_done: cover property (
		rsp_valid && read_not_write);
	cov_write_wait: cover property (
		!mem_write_strobe_n [*3] ##1 rsp_valid);
	cov_grant: cover property (
		$fell(bus_grant_ack_n) ##[1:20] $rose(bus_grant_ack_n));
	cov_pending: cover property (
		oe_pin_mode && !mem_oe_pend_n && !bus_grant_ack_n);
endmodule : ems_bus_interface

// ===== testbench/ems_mem_model.sv
`timescale 1ns/1ns
module ems_mem_model
	import ems_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic [3:0]  max_wait,
	input  wire logic [23:0] mem_addr,
	input  wire logic [31:0] mem_data_out,
	input  wire logic [3:0]  byte_select_n,
	input  wire logic        data_strobe_n,
	input  wire logic        mem_write_strobe_n,
	input  wire logic        read_not_write,
	output logic [31:0]      mem_data_in,
	output logic             sync_ready_n
);
	logic [31:0] mem [16];
	int          wait_left;
	initial begin
		foreach (mem[i]) mem[i] = 32'h0;
		mem_data_in = 32'h0;
		sync_ready_n = 1'b1;
		wait_left = 0;
	end
	// data only valid once ready is given; else a moving pattern
	always @(negedge sys_clk) begin
		if (data_strobe_n !== 1'b0) begin
			sync_ready_n <= 1'b1;
			wait_left <= $urandom_range(int'(max_wait), 0);
			mem_data_in <= ~mem_data_in;
		end else if (wait_left != 0) begin
			wait_left <= wait_left - 1;
			mem_data_in <= ~mem_data_in;
		end else begin
			sync_ready_n <= 1'b0;
			mem_data_in <= read_not_write ? mem[mem_addr[3:0]] : ~mem_data_in;
		end
	end
	always @(posedge sys_clk) begin
		if (!data_strobe_n && !mem_write_strobe_n && !sync_ready_n) begin
			for (int i = 0; i < 4; i++) begin
				if (!byte_select_n[i]) mem[mem_addr[3:0]][8*i+:8] <= mem_data_out[8*i+:8];
			end
		end
	end
endmodule : ems_mem_model

// ===== testbench/ems_bus_interface_tb.sv
`timescale 1ns/1ns
module ems_bus_interface_tb;
	import ems_pkg::*;
	logic        sys_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0;
	logic        req_write = 1'b0, oe_pin_mode = 1'b0, bus_request_n = 1'b1;
	logic [23:0] req_addr = 24'h0;
	logic [31:0] req_wdata = 32'h0;
	logic [3:0]  req_byte_en = 4'h0, max_wait = 4'h0;
	logic        req_ready, rsp_valid, ctrl_oe, mem_addr_oe, mem_data_oe;
	logic        cycle_initiate_n, addr_strobe_n, data_strobe_n;
	logic        mem_write_strobe_n, read_not_write, mem_oe_pend_n;
	logic        mem_oe_pend_oe, sync_ready_n, bus_grant_ack_n;
	logic [31:0] rsp_rdata, mem_data_out, mem_data_in;
	logic [23:0] mem_addr;
	logic [3:0]  byte_select_n;
	logic [31:0] shadow [16];
	int          num_errors = 0, num_checks = 0, cycles = 0;
	always #4 sys_clk = ~sys_clk;
	ems_bus_interface u_ems_bus_interface (.*);
	ems_mem_model u_ems_mem_model (.*);
	task automatic chk(input string name, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s exp %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	function automatic logic [31:0] merge(logic [31:0] o, n, logic [3:0] be);
		for (int i = 0; i < 4; i++) if (be[i]) o[8*i+:8] = n[8*i+:8];
		return o;
	endfunction : merge
	// called and returns at a falling edge
	task automatic xfer(input logic w, input logic [23:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		{req_write, req_addr, req_wdata, req_byte_en} = {w, a, d, be};
		req_valid = 1'b1;
		for (n = 0; req_ready !== 1'b1 && n < 100; n++) @(negedge sys_clk);
		chk("ready", req_ready, 1);
		@(negedge sys_clk);
		req_valid = 1'b0;
		chk("cyc_init", cycle_initiate_n, 0);
		chk("addr_stb", addr_strobe_n, 0);
		chk("byte_sel", byte_select_n, 4'(~be));
		chk("rnw", read_not_write, !w);
		for (n = 0; rsp_valid !== 1'b1 && n < 100; n++) begin
			@(negedge sys_clk);
			chk("addr", mem_addr, a);
			chk("ctrl_oe", ctrl_oe, 1);
			if (w) chk("wstb", mem_write_strobe_n, data_strobe_n);
			if (w && !data_strobe_n) chk("wdata", mem_data_out, d);
			if (!data_strobe_n) chk("data_oe", mem_data_oe, w);
			if (!data_strobe_n)
				chk("oe_pin", mem_oe_pend_n, w | oe_pin_mode);
		end
		chk("done", n < 100, 1);
		if (w) shadow[a[3:0]] = merge(shadow[a[3:0]], d, be);
		else chk("rdata", rsp_rdata, shadow[a[3:0]]);
		chk("idle_sel", byte_select_n, 4'hf);
	endtask : xfer
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		foreach (shadow[i]) shadow[i] = 32'h0;
		void'($urandom(32'hf210206d));
		repeat (16) @(negedge sys_clk);
		arst_n = 1'b1;
		@(negedge sys_clk);
		xfer(1, 24'h5, 32'ha5a5_1234, 4'hf);
		xfer(1, 24'h5, 32'h0ff0_eeee, 4'h5);
		xfer(0, 24'h5, 32'h0, 4'hf);
		for (int k = 0; k < 40; k++) begin
			max_wait = 4'($urandom_range(3, 0));
			xfer(1'($urandom), 24'($urandom), $urandom, 4'($urandom));
		end
		// release and regain the bus while an access waits
		oe_pin_mode = 1'b1;
		bus_request_n = 1'b0;
		@(negedge sys_clk);
		chk("rel_ctrl", ctrl_oe, 0);
		chk("rel_addr", mem_addr_oe, 0);
		chk("rel_data", mem_data_oe, 0);
		chk("early_ack", bus_grant_ack_n, 1);
		@(negedge sys_clk);
		chk("ack", bus_grant_ack_n, 0);
		{req_write, req_addr, req_byte_en} = {1'b0, 24'h5, 4'hf};
		req_valid = 1'b1;
		@(negedge sys_clk);
		chk("pend", mem_oe_pend_n, 0);
		chk("pend_oe", mem_oe_pend_oe, 1);
		chk("refused", req_ready, 0);
		bus_request_n = 1'b1;
		@(negedge sys_clk);
		chk("ack_off", bus_grant_ack_n, 1);
		chk("regain", ctrl_oe, 1);
		xfer(0, 24'h5, 32'h0, 4'hf);
		oe_pin_mode = 1'b0;
		// request arrives during a slow transfer
		max_wait = 4'h5;
		fork
			xfer(1, 24'h9, 32'hdead_0001, 4'hf);
			begin
				repeat (2) @(negedge sys_clk);
				bus_request_n = 1'b0;
			end
		join
		repeat (2) @(negedge sys_clk);
		chk("late_ack", bus_grant_ack_n, 0);
		chk("late_rel", ctrl_oe, 0);
		chk("rel_pin", mem_oe_pend_oe, 0);
		bus_request_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		xfer(0, 24'h9, 32'h0, 4'hf);
		print_verdict();
	end
endmodule : ems_bus_interface_tb
